// ===== hw/sar_adc_defs.svh
/*
  register offsets, field positions, reset values and timing counts
  for the successive-approximation converter control block.
  assumes inclusion by sar_adc_control.sv and the bench only, not by sar_adc_pkg.sv.
*/
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH

// wishbone byte offsets, one 32-bit word per register
`define OFS_CONV_CONTROL   5'h00
`define OFS_PORT_REF_CFG   5'h04
`define OFS_TIMING_FMT_CFG 5'h08
`define OFS_RESULT_HIGH    5'h0c
`define OFS_RESULT_LOW     5'h10
`define OFS_STATUS         5'h14

// conversion_control fields
`define BIT_CAL_NEXT       7
`define BIT_GO_DONE        1
`define BIT_CONV_ON        0
// port_reference_config fields
`define BIT_NEG_REF        5
`define BIT_POS_REF        4
// timing_format_config fields
`define BIT_RES_FMT        7
// status fields
`define BIT_DONE_FLAG      0

`define CTRL_RESET         8'h00
`define TIMING_RESET       8'h00
`define PMAP_STRAP_ANALOG  4'h0
`define PMAP_STRAP_DIGITAL 4'h7

// timing in conversion bit periods and clocks, and the first sar trial code
`define CONV_TADS          5'h0b
`define HOLDOFF_TADS       5'h02
`define TCY_CLKS           3'h4
`define SAR_MSB_TRIAL      10'h200

`endif

// ===== hw/sar_adc_pkg.sv
/*
  types shared by the converter control block: state encoding,
  the wishbone request carrier and the complete register state.
  uses no macros and does not need sar_adc_defs.svh on the include path.
*/
package sar_adc_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_DELAY = 5'h02,
    ST_ACQ   = 5'h04,
    ST_CONV  = 5'h08,
    ST_WAIT  = 5'h10
  } adc_state_e;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [4:0]  adr;
    logic        lane0;
    logic [7:0]  wdat;
  } wb_req_s;

  typedef struct packed {
    adc_state_e  st;
    logic        cal, go, on, nref, pref, fmt, flag, init, ack, sample, calact;
    logic [3:0]  chan, pmap;
    logic [2:0]  acq, cks, dly;
    logic [7:0]  res_hi, res_lo;
    logic [6:0]  div;
    logic [4:0]  tadc;
    logic [9:0]  sar;
    logic [12:0] amask;
    logic [31:0] rdat;
  } adc_regs_s;
endpackage

// ===== hw/sar_adc_control.sv
/*
  control logic of a 10-bit successive-approximation converter:
  register file on a classic wishbone slave, conversion clock select,
  acquisition timer, sar sequencer, abort and hold-off handling.
  assumes an analog front end that samples while sample_out is high and
  answers each trial code on comparator_in one clock later or earlier;
  rc_tick_in is a one-clock pulse per internal rc conversion period.
*/
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_defs.svh"

// Operation
// - calibrate-next bit set makes the next conversion a calibration one
// - channel select codes 0 to 12 route that input; 13 to 15 none
// - conversion on an unimplemented channel still completes normally
// - go/done reads one while converting, zero when idle
// - converter-on bit enables the module, clearing disables it
// - reference bits choose external pins or supply and ground
// - pin map codes above 2 turn inputs digital from the top down
// - pin map reset value follows the analog-default strap
// - result format bit picks right or left justification
// - acquisition codes give 0,2,4,6,8,12,16,20 bit periods
// - clock codes give oscillator divisions or the internal rc clock
// - rc clock start waits one instruction cycle after go
// - only the rc clock keeps converting during sleep
// - results come from successive approximation of held sample
// - reset restores registers, turns converter off, aborts conversion
// - completion loads result, clears go/done, sets done flag
// - nonzero acquisition time samples after go before converting
// - two bit periods pass after a conversion before new acquisition
// - unimplemented register bits read as zero
// - each conversion lasts eleven bit periods
// - clearing go/done aborts and keeps the previous result
// - sampling resumes on the selected channel after the wait
module sar_adc_control
  import sar_adc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [4:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        comparator_in,
  input  wire logic        rc_tick_in,
  input  wire logic        sleep_in,
  input  wire logic        portb_analog_default_in,
  output logic      [3:0]  channel_select_out,
  output logic      [12:0] analog_pins_out,
  output logic             neg_ref_select_out,
  output logic             pos_ref_select_out,
  output logic             converter_on_out,
  output logic             sample_out,
  output logic      [9:0]  sar_trial_out,
  output logic             calibrate_out,
  output logic             conversion_done_flag_out
);

  localparam adc_regs_s RESET_REGS = '{st: ST_IDLE, default: '0};

  adc_regs_s s_ff;
  adc_regs_s nxt_s;
  wb_req_s   req;
  logic      rc_sel;
  logic      tick;
  logic      wr;
  logic [3:0] bitpos;

  function automatic logic [6:0] tad_div(input logic [2:0] code);
    case (code)
      3'h0:    tad_div = 7'h02;
      3'h1:    tad_div = 7'h08;
      3'h2:    tad_div = 7'h20;
      3'h4:    tad_div = 7'h04;
      3'h5:    tad_div = 7'h10;
      3'h6:    tad_div = 7'h40;
      default: tad_div = 7'h02;
    endcase
  endfunction

  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h0:    acq_tads = 5'h00;
      3'h1:    acq_tads = 5'h02;
      3'h2:    acq_tads = 5'h04;
      3'h3:    acq_tads = 5'h06;
      3'h4:    acq_tads = 5'h08;
      3'h5:    acq_tads = 5'h0c;
      3'h6:    acq_tads = 5'h10;
      default: acq_tads = 5'h14;
    endcase
  endfunction

  // bit i set means input i is analog
  function automatic logic [12:0] analog_mask(input logic [3:0] code);
    logic [12:0] m;
    m = 13'h1fff;
    if (code > 4'h2) begin
      m = 13'h1fff >> (code - 4'h2);
    end
    analog_mask = m;
  endfunction

  assign req = '{valid: wb_cyc_in & wb_stb_in & ~s_ff.ack,
                 we:    wb_we_in,
                 adr:   wb_adr_in,
                 lane0: wb_sel_in[0],
                 wdat:  wb_dat_in[7:0]};

  always_comb begin
    nxt_s  = s_ff;
    nxt_s.ack = req.valid;
    wr     = req.valid & req.we & req.lane0;
    rc_sel = (s_ff.cks[1:0] == 2'h3);
    tick   = 1'b0;
    bitpos = 4'h0;

    // strap caught on the first clock after reset release
    if (!s_ff.init) begin
      nxt_s.init = 1'b1;
      nxt_s.pmap = portb_analog_default_in ? `PMAP_STRAP_ANALOG
                                           : `PMAP_STRAP_DIGITAL;
    end

    if (rc_sel) begin
      tick = rc_tick_in;
    end else if (!sleep_in) begin
      if (s_ff.div == tad_div(s_ff.cks) - 7'h01) begin
        nxt_s.div = 7'h00;
        tick = 1'b1;
      end else begin
        nxt_s.div = s_ff.div + 7'h01;
      end
    end

    // software writes to flag and result come first so hardware wins
    if (wr && req.adr == `OFS_STATUS && req.wdat[`BIT_DONE_FLAG]) begin
      nxt_s.flag = 1'b0;
    end
    if (wr && req.adr == `OFS_RESULT_HIGH) begin
      nxt_s.res_hi = req.wdat;
    end
    if (wr && req.adr == `OFS_RESULT_LOW) begin
      nxt_s.res_lo = req.wdat;
    end

    case (s_ff.st)
      ST_IDLE: begin
        // no channel check: unimplemented codes convert a floating input
        if (s_ff.go) begin
          nxt_s.div  = 7'h00;
          nxt_s.tadc = 5'h00;
          nxt_s.dly  = 3'h0;
          nxt_s.st   = rc_sel ? ST_DELAY : ST_ACQ;
        end
      end
      ST_DELAY: begin
        nxt_s.dly = s_ff.dly + 3'h1;
        if (s_ff.dly == `TCY_CLKS - 3'h1) begin
          nxt_s.st = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (acq_tads(s_ff.acq) == 5'h00) begin
          nxt_s.st = ST_CONV;
        end else if (tick) begin
          if (s_ff.tadc == acq_tads(s_ff.acq) - 5'h01) begin
            nxt_s.st   = ST_CONV;
            nxt_s.tadc = 5'h00;
          end else begin
            nxt_s.tadc = s_ff.tadc + 5'h01;
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          if (s_ff.tadc == 5'h00) begin
            nxt_s.sar = `SAR_MSB_TRIAL;
          end else begin
            bitpos = 4'(5'h0a - s_ff.tadc);
            nxt_s.sar[bitpos] = s_ff.sar[bitpos] & comparator_in;
            if (bitpos != 4'h0) begin
              nxt_s.sar[bitpos - 4'h1] = 1'b1;
            end
          end
          if (s_ff.tadc == `CONV_TADS - 5'h01) begin
            nxt_s.go   = 1'b0;
            nxt_s.flag = 1'b1;
            nxt_s.st   = ST_WAIT;
            nxt_s.tadc = 5'h00;
            if (s_ff.fmt) begin
              nxt_s.res_hi = {6'h00, nxt_s.sar[9:8]};
              nxt_s.res_lo = nxt_s.sar[7:0];
            end else begin
              nxt_s.res_hi = nxt_s.sar[9:2];
              nxt_s.res_lo = {nxt_s.sar[1:0], 6'h00};
            end
          end else begin
            nxt_s.tadc = s_ff.tadc + 5'h01;
          end
        end
      end
      ST_WAIT: begin
        if (tick) begin
          if (s_ff.tadc == `HOLDOFF_TADS - 5'h01) begin
            nxt_s.st   = ST_IDLE;
            nxt_s.tadc = 5'h00;
          end else begin
            nxt_s.tadc = s_ff.tadc + 5'h01;
          end
        end
      end
      default: begin
        nxt_s.st = ST_IDLE;
      end
    endcase

    if (wr && req.adr == `OFS_CONV_CONTROL) begin
      nxt_s.cal  = req.wdat[`BIT_CAL_NEXT];
      nxt_s.chan = req.wdat[5:2];
      nxt_s.on   = req.wdat[`BIT_CONV_ON];
      if (!req.wdat[`BIT_CONV_ON]) begin
        nxt_s.go = 1'b0;
        nxt_s.st = ST_IDLE;
      end else if (s_ff.go && !req.wdat[`BIT_GO_DONE]) begin
        // abort leaves the result pair untouched
        nxt_s.go = 1'b0;
        if (s_ff.st != ST_IDLE) begin
          nxt_s.st   = ST_WAIT;
          nxt_s.tadc = 5'h00;
          nxt_s.div  = 7'h00;
        end
      end else if (req.wdat[`BIT_GO_DONE] && s_ff.on) begin
        // go in the same write that turns the module on is ignored
        nxt_s.go = 1'b1;
      end
    end
    if (wr && req.adr == `OFS_PORT_REF_CFG) begin
      nxt_s.nref = req.wdat[`BIT_NEG_REF];
      nxt_s.pref = req.wdat[`BIT_POS_REF];
      nxt_s.pmap = req.wdat[3:0];
    end
    if (wr && req.adr == `OFS_TIMING_FMT_CFG) begin
      nxt_s.fmt = req.wdat[`BIT_RES_FMT];
      nxt_s.acq = req.wdat[5:3];
      nxt_s.cks = req.wdat[2:0];
    end

    nxt_s.rdat = 32'h0000_0000;
    if (req.valid && !req.we) begin
      case (req.adr)
        `OFS_CONV_CONTROL:
          nxt_s.rdat[7:0] = {s_ff.cal, 1'b0, s_ff.chan,
                             s_ff.go, s_ff.on};
        `OFS_PORT_REF_CFG:
          nxt_s.rdat[7:0] = {2'h0, s_ff.nref, s_ff.pref, s_ff.pmap};
        `OFS_TIMING_FMT_CFG:
          nxt_s.rdat[7:0] = {s_ff.fmt, 1'b0, s_ff.acq, s_ff.cks};
        `OFS_RESULT_HIGH: nxt_s.rdat[7:0] = s_ff.res_hi;
        `OFS_RESULT_LOW:  nxt_s.rdat[7:0] = s_ff.res_lo;
        `OFS_STATUS:
          nxt_s.rdat[7:0] = {6'h00, s_ff.st != ST_IDLE, s_ff.flag};
        default: nxt_s.rdat = 32'h0000_0000;
      endcase
    end

    nxt_s.sample = nxt_s.on & (nxt_s.st == ST_IDLE || nxt_s.st == ST_DELAY ||
                               nxt_s.st == ST_ACQ);
    nxt_s.calact = nxt_s.cal & (nxt_s.st == ST_CONV);
    nxt_s.amask  = analog_mask(nxt_s.pmap);
  end

  // async reset loads constants only; the strap is taken a clock later
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_ff <= RESET_REGS;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign wb_dat_out               = s_ff.rdat;
  assign wb_ack_out               = s_ff.ack;
  assign channel_select_out       = s_ff.chan;
  assign analog_pins_out          = s_ff.amask;
  assign neg_ref_select_out       = s_ff.nref;
  assign pos_ref_select_out       = s_ff.pref;
  assign converter_on_out         = s_ff.on;
  assign sample_out               = s_ff.sample;
  assign sar_trial_out            = s_ff.sar;
  assign calibrate_out            = s_ff.calact;
  assign conversion_done_flag_out = s_ff.flag;

endmodule // sar_adc_control

`default_nettype wire

// ===== bench/sar_adc_front_end.sv
/* analog front end model: tracks the level while sampled and holds it after, compares trials,
   free-running rc tick. assumes the bench sets level_in. */
`timescale 1ns/10ps
`default_nettype none
module sar_adc_front_end #(parameter int RC_DIV = 6) (
  input  wire logic       clk_in,
  input  wire logic       sample_in,
  input  wire logic [9:0] trial_in,
  input  wire logic [9:0] level_in,
  output logic            cmp_out,
  output logic            tick_out
);
  logic [9:0] held_ff = 10'h000;
  int         cnt_ff = 0;
  always_ff @(posedge clk_in) begin
    if (sample_in)
      held_ff <= level_in;
    cnt_ff <= (cnt_ff == RC_DIV - 1) ? 0 : cnt_ff + 1;
  end
  // the held level stays put once sampling stops, as a real hold cap would
  assign cmp_out  = held_ff >= trial_in;
  assign tick_out = cnt_ff == 0;
endmodule // sar_adc_front_end
`default_nettype wire

// ===== bench/sar_adc_control_assertions.sv
/* port checker for the converter control block.
   assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_assertions (
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        sample_out,
  input wire logic [9:0]  sar_trial_out,
  input wire logic        calibrate_out,
  input wire logic        converter_on_out,
  input wire logic        conversion_done_flag_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence ack_pulse_s;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  sequence hold_off_s;
    !sample_out [*3];
  endsequence
  bus_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> ack_pulse_s)
    else $error("bus request without a single ack");
  read_pad_a: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
    else $error("upper read bits not zero");
  reset_off_a: assert property (disable iff (1'b0)
    !reset_n_in |-> !converter_on_out && !sample_out && !conversion_done_flag_out)
    else $error("outputs active during reset");
  off_quiet_a: assert property (!converter_on_out |-> !sample_out && !calibrate_out)
    else $error("activity while converter off");
  cal_conv_a: assert property (calibrate_out |-> !sample_out)
    else $error("calibrate flagged while sampling");
  hold_off_a: assert property ($rose(conversion_done_flag_out) |-> hold_off_s)
    else $error("sampling resumed too early");
  msb_first_a: assert property ($fell(sample_out) && converter_on_out
    |-> ##[0:300] sar_trial_out == 10'h200)
    else $error("conversion did not start at midscale");
  resume_a: assert property ($rose(conversion_done_flag_out)
    |-> ##[3:700] (sample_out || !converter_on_out))
    else $error("sampling not resumed");
endmodule // sar_adc_control_assertions
bind sar_adc_control sar_adc_control_assertions sar_adc_control_assertions_i (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .sample_out(sample_out),
  .sar_trial_out(sar_trial_out), .calibrate_out(calibrate_out),
  .converter_on_out(converter_on_out), .conversion_done_flag_out(conversion_done_flag_out));
`default_nettype wire

// ===== bench/sar_adc_control_tb.sv
/* self-checking bench: register checks, random conversions, abort, reset.
   assumes the front end model, the checker and the design are compiled. */
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_defs.svh"
module sar_adc_control_tb;
  localparam int RC_DIV = 6;
  logic        clk = 0, rst_n = 1, cyc = 0, stb = 0, we = 0, slp = 0;
  logic        cmp, tick, ack, nref, pref, on, smp, cal_o, flag, saw_cal = 0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [9:0]  level = 10'h000, trial;
  logic [12:0] pins;
  logic [3:0]  chan;
  int          fails = 0, cmp_count = 0, cyc_n = 0, t_done = 0;
  always #20 clk = ~clk;
  sar_adc_control sar_adc_control_i (
    .clk_in(clk), .reset_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .comparator_in(cmp), .rc_tick_in(tick), .sleep_in(slp), .portb_analog_default_in(1'b1),
    .channel_select_out(chan), .analog_pins_out(pins), .neg_ref_select_out(nref),
    .pos_ref_select_out(pref), .converter_on_out(on), .sample_out(smp),
    .sar_trial_out(trial), .calibrate_out(cal_o), .conversion_done_flag_out(flag));
  sar_adc_front_end #(.RC_DIV(RC_DIV)) sar_adc_front_end_i (.clk_in(clk), .sample_in(smp),
    .trial_in(trial), .level_in(level), .cmp_out(cmp), .tick_out(tick));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (flag === 1'b1 && t_done == 0)
      t_done <= cyc_n;
    if (cal_o === 1'b1)
      saw_cal <= 1'b1;
    if (cyc_n > 20000) begin
      fails = fails + 1;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; strobe stays low for a full cycle before the next one
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    // look at ack mid-cycle, where it has settled, then release at the next rising edge
    do @(negedge clk); while (ack !== 1'b1);
    q = rdat;
    @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  function automatic logic [12:0] exp_pins(input logic [3:0] m);
    return (m < 4'h3) ? 13'h1fff : 13'h1fff >> (m - 4'h2);
  endfunction
  function automatic int tad_of(input logic [2:0] c);
    int t [8] = '{2, 8, 32, RC_DIV, 4, 16, 64, RC_DIV};
    return t[c];
  endfunction
  function automatic int acq_of(input logic [2:0] c);
    int t [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    return t[c];
  endfunction
  initial begin
    logic [31:0] q;
    logic [15:0] r16;
    logic [2:0]  aq, ck;
    logic [3:0]  ch;
    logic        f, c;
    int          n, lo, e, d, conv_bit_period;
    rst_n <= 1'b0;
    q = $urandom(41334);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(`OFS_CONV_CONTROL, 32'h0);
    rd_chk(`OFS_PORT_REF_CFG, 32'h0);
    rd_chk(`OFS_TIMING_FMT_CFG, 32'h0);
    rd_chk(5'h18, 32'h0);
    wr(`OFS_PORT_REF_CFG, 8'hdf);
    rd_chk(`OFS_PORT_REF_CFG, 32'h1f);
    chk({30'h0, nref, pref}, 32'h1);
    for (n = 0; n < 16; n++) begin
      wr(`OFS_PORT_REF_CFG, {4'h2, 4'(n)});
      chk({19'h0, pins}, {19'h0, exp_pins(4'(n))});
    end
    chk({30'h0, nref, pref}, 32'h2);
    wr(`OFS_TIMING_FMT_CFG, 8'hff);
    rd_chk(`OFS_TIMING_FMT_CFG, 32'hbf);
    wr(`OFS_CONV_CONTROL, 8'hff);
    rd_chk(`OFS_CONV_CONTROL, 32'hbd);
    chk({28'h0, chan}, 32'hf);
    for (n = 0; n < 12; n++) begin
      ck = 3'(n);
      aq = 3'(n * 3);
      f = 1'($urandom);
      c = 1'($urandom);
      ch = 4'($urandom);
      level <= 10'($urandom);
      slp <= ck[1] & ck[0];
      wr(`OFS_TIMING_FMT_CFG, {f, 1'b0, aq, ck});
      wr(`OFS_CONV_CONTROL, {c, 1'b0, ch, 2'b01});
      wr(`OFS_STATUS, 8'h01);
      t_done = 0;
      saw_cal = 1'b0;
      lo = cyc_n;
      wr(`OFS_CONV_CONTROL, {c, 1'b0, ch, 2'b11});
      do bus(1'b0, `OFS_CONV_CONTROL, 8'h00, q); while (q[1] === 1'b1);
      while (smp !== 1'b1) @(posedge clk);
      conv_bit_period = tad_of(ck);
      e = (acq_of(aq) + 11) * conv_bit_period + ((ck[1] & ck[0]) ? 4 : 0);
      d = t_done - lo;
      chk(32'(d >= e - conv_bit_period && d <= e + conv_bit_period + 8), 32'h1);
      chk({31'h0, saw_cal}, {31'h0, c});
      r16 = f ? {6'h0, level} : {level, 6'h0};
      rd_chk(`OFS_RESULT_HIGH, {24'h0, r16[15:8]});
      rd_chk(`OFS_RESULT_LOW, {24'h0, r16[7:0]});
      bus(1'b0, `OFS_STATUS, 8'h00, q);
      chk({31'h0, q[0]}, 32'h1);
    end
    slp <= 1'b0;
    wr(`OFS_TIMING_FMT_CFG, {f, 7'h05});
    level <= ~level;
    wr(`OFS_CONV_CONTROL, 8'h03);
    // land inside the eleven bit periods of a divide-by-16 conversion
    repeat (60) @(posedge clk);
    wr(`OFS_CONV_CONTROL, 8'h01);
    rd_chk(`OFS_CONV_CONTROL, 32'h01);
    rd_chk(`OFS_RESULT_HIGH, {24'h0, r16[15:8]});
    rd_chk(`OFS_RESULT_LOW, {24'h0, r16[7:0]});
    while (smp !== 1'b1) @(posedge clk);
    wr(`OFS_CONV_CONTROL, 8'h03);
    repeat (40) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, on}, 32'h0);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(`OFS_CONV_CONTROL, 32'h0);
    print_verdict();
  end
endmodule // sar_adc_control_tb
`default_nettype wire
